// *** sbm_pkg.sv ***
package sbm_pkg;

  // depth of the synchroniser on every pin input
  localparam int SBM_SYNC_STAGES = 2;
  // width of a latency select field
  localparam int SBM_LAT_W = 2;
  // slots in the read and write latency pipes (latency 0..3)
  localparam int SBM_LAT_SLOTS = 4;
  // entries in the read data buffer
  localparam int SBM_BUF_DEPTH = 2;
  // deselect ticks inserted after a burst in address strobe mode
  localparam int SBM_DESEL_TICKS = 1;
  // strobe function select encodings
  localparam logic SBM_FN_ADDR_STROBE = 1'b0;
  localparam logic SBM_FN_READ_ENABLE = 1'b1;
  // value of an active low pin at rest and after reset
  localparam logic SBM_PIN_IDLE = 1'b1;
  // link clock period seen in the bench, in ns
  localparam int SBM_LINK_PERIOD_NS = 48;
  // system clock period, in ns
  localparam int SBM_SYS_PERIOD_NS = 5;

  // access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_DESEL = 2'b11
  } sbm_state_e;

endpackage : sbm_pkg

// *** sbm_rd_buf.sv ***
`timescale 1ns/1ps
// small fifo of registers; read data come straight from a register
module sbm_rd_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_sys_rst,
  // filling side
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [WIDTH-1:0]           i_in_data,
  // draining side
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [WIDTH-1:0]                o_out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]      o_count
);
  import sbm_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];       // storage words
  logic [PW-1:0]    wr_ptr;            // next slot to fill
  logic [PW-1:0]    rd_ptr;            // oldest slot
  logic [CW-1:0]    count;             // words held
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != CW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign o_count     = count;

  // pointer and level update
  always_comb begin
    push        = i_in_valid & o_in_ready;
    pop         = o_out_valid & i_out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + CW'(push) - CW'(pop);
  end

  // registers; storage needs no reset
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

endmodule : sbm_rd_buf

// *** sbm_port.sv ***
`timescale 1ns/1ps
//
// Contract
// - read latency zero to three per space
// - write latency zero to three per space
// - strobe select clear: address strobe, deselects
// - strobe select set: read enable, no deselect
// - per space choice of external clock
// - extend clear: chip select drops after command
// - extend set: chip select follows output enable
// - shared pins carry strobe, enable, write
module sbm_port #(
  parameter int NUM_SPACES = 4,
  parameter int AW         = 20,
  parameter int DW         = 32,
  parameter int BW         = 4
) (
  // system clock and reset
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_sys_rst,
  // the two external clocks, sampled here
  input  wire logic                              i_ext_clock_out_one,
  input  wire logic                              i_ext_clock_out_two,
  // per space configuration
  input  wire logic [NUM_SPACES-1:0][sbm_pkg::SBM_LAT_W-1:0]
                                                 i_read_latency_sel,
  input  wire logic [NUM_SPACES-1:0][sbm_pkg::SBM_LAT_W-1:0]
                                                 i_write_latency_sel,
  input  wire logic [NUM_SPACES-1:0]             i_strobe_function_sel,
  input  wire logic [NUM_SPACES-1:0]             i_sync_clock_sel,
  input  wire logic [NUM_SPACES-1:0]             i_chip_select_extend,
  // access requests
  input  wire logic                              i_req_valid,
  output logic                                   o_req_ready,
  input  wire logic                              i_req_write,
  input  wire logic [$clog2(NUM_SPACES)-1:0]     i_req_space,
  input  wire logic [AW-1:0]                     i_req_addr,
  input  wire logic [BW-1:0]                     i_req_be,
  input  wire logic [DW-1:0]                     i_req_wdata,
  // read data out
  output logic                                   o_rd_valid,
  input  wire logic                              i_rd_ready,
  output logic [DW-1:0]                          o_rd_data,
  // status
  output logic                                   o_busy,
  // memory pins
  output logic [NUM_SPACES-1:0]                  o_space_chip_select_n,
  output logic                                   o_addr_strobe_or_read_enable_n,
  output logic                                   o_sync_output_enable_n,
  output logic                                   o_sync_write_enable_n,
  output logic [AW-1:0]                          o_ext_addr_bus,
  output logic [BW-1:0]                          o_byte_lane_strobes,
  input  wire logic [DW-1:0]                     i_ext_data_bus,
  output logic [DW-1:0]                          o_ext_data_bus,
  output logic                                   o_ext_data_bus_oe
);
  import sbm_pkg::*;

  localparam int SW = $clog2(NUM_SPACES);
  localparam int CW = $clog2(SBM_BUF_DEPTH+1);

  // synchronisers: stage one is read only by stage two
  logic [1:0]    clk_s1;
  logic [1:0]    clk_s2;
  logic [1:0]    clk_s3;              // edge history, fed from stage two
  logic [DW-1:0] dq_s1;
  logic [DW-1:0] dq_s2;
  logic [1:0]    clk_rise;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      clk_s1 <= '0;
      clk_s2 <= '0;
      clk_s3 <= '0;
      dq_s1  <= '0;
      dq_s2  <= '0;
    end else begin
      clk_s1 <= {i_ext_clock_out_two, i_ext_clock_out_one};
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dq_s1  <= i_ext_data_bus;
      dq_s2  <= dq_s1;
    end
  end

  // rising edge of each external clock, one cycle pulse
  assign clk_rise = clk_s2 & ~clk_s3;

  // sequencer state
  sbm_state_e                  state, next_state;
  logic [SW-1:0]               cur_space, next_cur_space;
  logic [SBM_LAT_SLOTS-1:0]    rd_shift, next_rd_shift;  // reads in flight
  logic [SBM_LAT_SLOTS-1:0]    wr_vld, next_wr_vld;      // writes pending
  logic [DW-1:0]               wr_dat [SBM_LAT_SLOTS];
  logic [DW-1:0]               next_wr_dat [SBM_LAT_SLOTS];
  // registered pins
  logic [NUM_SPACES-1:0]       ce_n, next_ce_n;
  logic                        ads_n, next_ads_n;
  logic                        oe_n, next_oe_n;
  logic                        we_n, next_we_n;
  logic [AW-1:0]               addr, next_addr;
  logic [BW-1:0]               be, next_be;
  logic [DW-1:0]               dq_out, next_dq_out;
  logic                        dq_oe, next_dq_oe;
  // decode terms
  logic [SW-1:0]               sel_space;     // space whose clock runs us
  logic                        tick;          // selected clock rose
  logic                        pipes_empty;
  logic                        space_ok;
  logic                        room;          // buffer can take one more
  logic                        can_take;
  logic                        issue;
  logic                        capture;
  logic [2:0]                  inflight;
  logic [CW-1:0]               buf_count;
  logic                        buf_in_ready;
  logic [SBM_LAT_W-1:0]        rl;
  logic [SBM_LAT_W-1:0]        wl;
  logic                        oe_on;

  // clock choice: the open access keeps its space's clock
  always_comb begin
    pipes_empty = ~|rd_shift & ~|wr_vld;
    sel_space   = (state == ST_IDLE && pipes_empty) ? i_req_space
                                                    : cur_space;
    tick        = clk_rise[i_sync_clock_sel[sel_space]];
  end

  // admission: same space and direction continues a burst
  always_comb begin
    inflight = 3'($countones(rd_shift)) + 3'(buf_count);
    room     = (inflight < 3'(SBM_BUF_DEPTH)) & buf_in_ready;
    unique case (state)
      ST_IDLE:  space_ok = pipes_empty;
      ST_READ:  space_ok = (i_req_space == cur_space) & ~i_req_write;
      ST_WRITE: space_ok = (i_req_space == cur_space) & i_req_write;
      ST_DESEL: space_ok = 1'b0;
    endcase
    can_take    = space_ok & (i_req_write | room);
    o_req_ready = tick & can_take;
    issue       = o_req_ready & i_req_valid;
    capture     = tick & rd_shift[0];
    rl          = i_read_latency_sel[i_req_space];
    wl          = i_write_latency_sel[i_req_space];
  end

  // sequencer next state
  always_comb begin
    next_state     = state;
    next_cur_space = cur_space;
    next_rd_shift  = rd_shift;
    next_wr_vld    = wr_vld;
    next_wr_dat    = wr_dat;
    if (tick) begin
      // latency pipes advance one slot per external clock
      next_rd_shift = rd_shift >> 1;
      next_wr_vld   = wr_vld >> 1;
      for (int i = 0; i < SBM_LAT_SLOTS - 1; i++) begin
        next_wr_dat[i] = wr_dat[i+1];
      end
      if (issue) begin
        next_cur_space = i_req_space;
        next_state     = i_req_write ? ST_WRITE : ST_READ;
        if (!i_req_write) begin
          // capture lands rl+1 ticks after the command
          next_rd_shift[rl] = 1'b1;
        end else if (wl != '0) begin
          // data goes out wl ticks after the command
          next_wr_vld[wl - 1'b1] = 1'b1;
          next_wr_dat[wl - 1'b1] = i_req_wdata;
        end
      end else begin
        unique case (state)
          ST_READ, ST_WRITE: begin
            // burst ended: burst memories get a deselect tick
            if (i_strobe_function_sel[cur_space] == SBM_FN_ADDR_STROBE) begin
              next_state = ST_DESEL;
            end else begin
              next_state = ST_IDLE;
            end
          end
          ST_DESEL: next_state = ST_IDLE;
          ST_IDLE:  next_state = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state     <= ST_IDLE;
      cur_space <= '0;
      rd_shift  <= '0;
      wr_vld    <= '0;
      for (int i = 0; i < SBM_LAT_SLOTS; i++) begin
        wr_dat[i] <= '0;
      end
    end else begin
      state     <= next_state;
      cur_space <= next_cur_space;
      rd_shift  <= next_rd_shift;
      wr_vld    <= next_wr_vld;
      wr_dat    <= next_wr_dat;
    end
  end

  // pin values, all changed only on the selected clock's rise
  always_comb begin
    next_ce_n   = ce_n;
    next_ads_n  = ads_n;
    next_oe_n   = oe_n;
    next_we_n   = we_n;
    next_addr   = addr;
    next_be     = be;
    next_dq_out = dq_out;
    next_dq_oe  = dq_oe;
    oe_on       = (issue & ~i_req_write) | (|next_rd_shift);
    if (tick) begin
      // output enable spans command to last capture
      next_oe_n  = ~oe_on;
      next_we_n  = ~(issue & i_req_write);
      next_ads_n = SBM_PIN_IDLE;
      next_ce_n  = {NUM_SPACES{SBM_PIN_IDLE}};
      if (issue) begin
        next_ce_n[i_req_space] = 1'b0;
        next_addr = i_req_addr;
        next_be   = i_req_be;
        if (i_strobe_function_sel[i_req_space] == SBM_FN_ADDR_STROBE) begin
          next_ads_n = 1'b0;
        end else begin
          next_ads_n = i_req_write;
        end
      end else if (i_chip_select_extend[cur_space] && oe_on) begin
        // fifo glue wants select held with output enable
        next_ce_n[cur_space] = 1'b0;
      end
      // write data drive: latency zero rides with the command
      if (issue && i_req_write && wl == '0) begin
        next_dq_out = i_req_wdata;
        next_dq_oe  = 1'b1;
      end else if (wr_vld[0]) begin
        next_dq_out = wr_dat[0];
        next_dq_oe  = 1'b1;
      end else begin
        next_dq_oe  = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ce_n   <= {NUM_SPACES{SBM_PIN_IDLE}};
      ads_n  <= SBM_PIN_IDLE;
      oe_n   <= SBM_PIN_IDLE;
      we_n   <= SBM_PIN_IDLE;
      addr   <= '0;
      be     <= '0;
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else begin
      ce_n   <= next_ce_n;
      ads_n  <= next_ads_n;
      oe_n   <= next_oe_n;
      we_n   <= next_we_n;
      addr   <= next_addr;
      be     <= next_be;
      dq_out <= next_dq_out;
      dq_oe  <= next_dq_oe;
    end
  end

  // read data buffer; room is reserved at issue so a capture never stalls
  sbm_rd_buf #(
    .WIDTH (DW),
    .DEPTH (SBM_BUF_DEPTH)
  ) u_rd_buf (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (capture),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (dq_s2),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data),
    .o_count     (buf_count)
  );

  // pin drive
  assign o_space_chip_select_n          = ce_n;
  assign o_addr_strobe_or_read_enable_n = ads_n;
  assign o_sync_output_enable_n         = oe_n;
  assign o_sync_write_enable_n          = we_n;
  assign o_ext_addr_bus                 = addr;
  assign o_byte_lane_strobes            = be;
  assign o_ext_data_bus                 = dq_out;
  assign o_ext_data_bus_oe              = dq_oe;
  assign o_busy = (state != ST_IDLE) | ~pipes_empty;

endmodule : sbm_port

// *** sbm_port_checker.sv ***
`timescale 1ns/1ps
// pin rules of the memory port, seen from its ports alone
module sbm_port_checker #(
  parameter int NUM_SPACES = 4,
  parameter int DW         = 32
) (
  // clocks and reset
  input wire logic                  i_sys_clk,
  input wire logic                  i_sys_rst,
  input wire logic                  i_ext_clock_out_one,
  input wire logic                  i_ext_clock_out_two,
  // space setup
  input wire logic [NUM_SPACES-1:0] i_strobe_function_sel,
  input wire logic [NUM_SPACES-1:0] i_chip_select_extend,
  // user side
  input wire logic                  o_req_ready,
  input wire logic                  o_rd_valid,
  input wire logic                  i_rd_ready,
  input wire logic [DW-1:0]         o_rd_data,
  // memory pins
  input wire logic [NUM_SPACES-1:0] o_space_chip_select_n,
  input wire logic                  o_addr_strobe_or_read_enable_n,
  input wire logic                  o_sync_output_enable_n,
  input wire logic                  o_sync_write_enable_n,
  input wire logic                  o_ext_data_bus_oe
);
  // pins turned active high for reading
  wire [NUM_SPACES-1:0] sel = ~o_space_chip_select_n;
  wire [NUM_SPACES-1:0] ext = i_chip_select_extend;
  wire [NUM_SPACES-1:0] ren = i_strobe_function_sel;
  wire                  ads = ~o_addr_strobe_or_read_enable_n;
  wire                  oe  = ~o_sync_output_enable_n;
  wire                  we  = ~o_sync_write_enable_n;
  logic [1:0]           ck_q;       // clock levels one cycle back
  logic [2:0]           since;      // cycles since a clock rise
  logic [2:0]           next_since;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // saturating count, restarted by a rise of either clock
  always_comb begin
    next_since = (since == 3'h7) ? since : since + 3'h1;
    if (|({i_ext_clock_out_two, i_ext_clock_out_one} & ~ck_q)) begin
      next_since = 3'h0;
    end
  end
  // helper registers; no reset, the clocks run from time zero
  always_ff @(posedge i_sys_clk) begin
    ck_q  <= {i_ext_clock_out_two, i_ext_clock_out_one};
    since <= next_since;
  end
  idle_after_reset_a: assert property ($fell(i_sys_rst) |->
    sel == '0 && !ads && !oe && !we && !o_ext_data_bus_oe && !o_rd_valid)
    else $error("pins not idle after reset");
  pins_on_tick_a: assert property (
    !$stable({sel, ads, oe, we, o_ext_data_bus_oe}) |-> since <= 3'h3)
    else $error("pin changed away from a clock rise");
  ready_pulse_a: assert property (o_req_ready |=> !o_req_ready)
    else $error("request ready held over two cycles");
  strobe_selects_a: assert property (ads |-> sel != '0)
    else $error("strobe without chip select");
  bus_turn_a: assert property (o_ext_data_bus_oe || we |-> !oe)
    else $error("write overlaps output enable");
  cs_drop_a: assert property ((sel & ~ext) != '0 |-> ads || we)
    else $error("chip select held with no command");
  cs_follow_oe_a: assert property (oe && $past(oe) &&
    ($past(sel) & ext) != '0 |-> (sel & $past(sel)) != '0)
    else $error("chip select dropped while output enabled");
  ads_on_write_a: assert property ((sel & ~ren) != '0 && we |-> ads)
    else $error("no address strobe on a write");
  ren_off_write_a: assert property ((sel & ren) != '0 && we |-> !ads)
    else $error("read enable on a write");
  rd_hold_a: assert property (o_rd_valid && !i_rd_ready |=>
    o_rd_valid && $stable(o_rd_data))
    else $error("read word lost before taken");
endmodule : sbm_port_checker

bind sbm_port sbm_port_checker #(
  .NUM_SPACES(NUM_SPACES),
  .DW(DW)
) i_chk (
  .i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst),
  .i_ext_clock_out_one(i_ext_clock_out_one),
  .i_ext_clock_out_two(i_ext_clock_out_two),
  .i_strobe_function_sel(i_strobe_function_sel),
  .i_chip_select_extend(i_chip_select_extend),
  .o_req_ready(o_req_ready),
  .o_rd_valid(o_rd_valid),
  .i_rd_ready(i_rd_ready),
  .o_rd_data(o_rd_data),
  .o_space_chip_select_n(o_space_chip_select_n),
  .o_addr_strobe_or_read_enable_n(o_addr_strobe_or_read_enable_n),
  .o_sync_output_enable_n(o_sync_output_enable_n),
  .o_sync_write_enable_n(o_sync_write_enable_n),
  .o_ext_data_bus_oe(o_ext_data_bus_oe)
);

// *** sbm_mem_model.sv ***
`timescale 1ns/1ps
// memory on the far side, answering on the selected clock
module sbm_mem_model (
  // clocks and the active space setup
  input  wire logic        i_ck1,
  input  wire logic        i_ck2,
  input  wire logic        i_csel,
  input  wire logic [1:0]  i_rl,
  input  wire logic [1:0]  i_wl,
  // pins of the port
  input  wire logic [3:0]  i_cs_n,
  input  wire logic        i_ads_n,
  input  wire logic        i_we_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [31:0] i_dq,
  output logic      [31:0] o_dq
);
  logic [31:0]      mem [logic [19:0]];  // written words
  logic [3:0][19:0] ra;                  // read address pipe
  logic [3:0][19:0] wa;                  // write address pipe
  logic [3:0]       rv = 4'h0;           // read pipe valid
  logic [3:0]       wv = 4'h0;           // write pipe valid
  logic             rc_q;                // read seen at the rise
  logic [19:0]      a_q;                 // address seen at the rise
  logic [31:0]      junk = 32'h0f0f_0f0f; // idle bus, flips half a period after each rise
  wire ck  = i_csel ? i_ck2 : i_ck1;     // clock of the active space
  wire sel = (i_cs_n != 4'hf);
  wire rc  = sel && !i_ads_n && i_we_n;  // read command on the pins
  // unwritten words read back as a pattern of the address
  function automatic logic [31:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : {12'ha5c, a};
  endfunction : rd
  // pins taken at the rise; read pipe moves half a period later
  always @(posedge ck) begin
    rc_q = rc;
    a_q  = i_addr;
    wv   = {wv[2:0], sel && !i_we_n};
    wa   = {wa[2:0], i_addr};
    if (wv[i_wl]) begin
      mem[wa[i_wl]] = i_dq; // undriven bus stores noise
    end
    #24;
    rv   = {rv[2:0], rc_q};
    ra   = {ra[2:0], a_q};
    junk = ~junk;
  end
  // due word exactly at the read latency, noise otherwise
  always @* begin
    if (i_rl == 2'd0)
      o_dq = rc ? rd(i_addr) : junk;
    else
      o_dq = rv[i_rl - 2'd1] ? rd(ra[i_rl - 2'd1]) : junk;
  end
endmodule : sbm_mem_model

// *** tb_sync_burst_memory_port.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_sync_burst_memory_port;
  logic            clk = 1'b0;     // system clock
  logic            rst = 1'b1;     // held for five cycles
  logic            ck1 = 1'b0;     // memory clocks
  logic            ck2 = 1'b0;
  logic [3:0][1:0] rl = 8'he4;     // space s has latency s
  logic [3:0]      strb = 4'hc;    // strobe function per space
  logic [3:0]      csel = 4'ha;    // clock choice per space
  logic [3:0]      ext = 4'ha;     // chip select extend per space
  logic            valid = 1'b0;   // request side
  logic            wr = 1'b0;
  logic [1:0]      space = 2'd0;
  logic [19:0]     addr = 20'h0;
  logic [31:0]     wdata = 32'h0;
  logic            rd_rdy = 1'b0;  // stalls unless popping
  logic            ready;
  logic            rd_valid;
  logic            ads_n;
  logic            oe_n;
  logic            we_n;
  logic            dq_oe;
  logic [31:0]     rd_data;
  logic [31:0]     dut_dq;
  logic [31:0]     mdl_dq;
  logic [3:0]      cs_n;
  logic [19:0]     ea;
  logic            busy;           // sequencer status
  logic [3:0]      be_q;           // byte strobes on the pins
  wire  [31:0]     dq = dq_oe ? dut_dq : mdl_dq; // level of shared bus
  int              err_count = 0;
  int              check_count = 0;
  // clocks; memory clocks free running with unrelated phase
  initial forever #2.5 clk = ~clk;
  initial forever #24 ck1 = ~ck1;
  initial begin
    #17;
    forever #24 ck2 = ~ck2;
  end
  sbm_port i_dut (
    .i_sys_clk(clk), .i_sys_rst(rst),
    .i_ext_clock_out_one(ck1), .i_ext_clock_out_two(ck2),
    .i_read_latency_sel(rl), .i_write_latency_sel(rl),
    .i_strobe_function_sel(strb), .i_sync_clock_sel(csel),
    .i_chip_select_extend(ext), .i_req_valid(valid),
    .o_req_ready(ready), .i_req_write(wr), .i_req_space(space),
    .i_req_addr(addr), .i_req_be(addr[3:0]), .i_req_wdata(wdata),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_rdy), .o_rd_data(rd_data),
    .o_busy(busy), .o_space_chip_select_n(cs_n),
    .o_addr_strobe_or_read_enable_n(ads_n),
    .o_sync_output_enable_n(oe_n), .o_sync_write_enable_n(we_n),
    .o_ext_addr_bus(ea), .o_byte_lane_strobes(be_q),
    .i_ext_data_bus(dq), .o_ext_data_bus(dut_dq),
    .o_ext_data_bus_oe(dq_oe)
  );
  sbm_mem_model i_mem (
    .i_ck1(ck1), .i_ck2(ck2), .i_csel(csel[space]),
    .i_rl(rl[space]), .i_wl(rl[space]), .i_cs_n(cs_n),
    .i_ads_n(ads_n), .i_we_n(we_n), .i_addr(ea), .i_dq(dq),
    .o_dq(mdl_dq)
  );
  // counts, verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // offer one request until taken or the bound runs out
  task automatic req(input logic w, input logic [1:0] s,
                     input logic [19:0] a, input logic take);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    wr    <= w;
    space <= s;
    addr  <= a;
    wdata <= {12'hc0d, a};
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      if (ready === 1'b1) break;
    end
    @(posedge clk);
    valid <= 1'b0;
    `CHK(n < 200, take)
    if (take && n == 200) results();
  endtask : req
  // wait for a read word, compare it, then pop it
  task automatic get(input logic [31:0] e);
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) break;
    end
    `CHK(rd_data, e)
    if (n == 300) begin
      err_count++;
      results();
    end
    @(posedge clk);
    rd_rdy <= 1'b1;
    @(posedge clk);
    rd_rdy <= 1'b0;
  endtask : get
  // every space and latency, both strobe and extend settings
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      strb <= p ? 4'h3 : 4'hc;
      ext  <= p ? 4'h5 : 4'ha;
      for (int s = 0; s < 4; s++) begin
        req(1'b1, 2'(s), 20'(p * 16 + s), 1'b1);
        req(1'b0, 2'(s), 20'(p * 16 + s), 1'b1);
        get({12'hc0d, 20'(p * 16 + s)});
      end
    end
    // back to back reads fill the buffer, a third is refused
    req(1'b1, 2'd2, 20'h7, 1'b1);
    req(1'b0, 2'd2, 20'h7, 1'b1);
    req(1'b0, 2'd2, 20'h7, 1'b1);
    req(1'b0, 2'd2, 20'h9, 1'b0);
    get({12'hc0d, 20'h7});
    get({12'hc0d, 20'h7});
    req(1'b0, 2'd2, 20'h9, 1'b1);
    // one settled look while the read is still in flight
    @(negedge clk);
    `CHK(busy, 1'b1)
    get({12'ha5c, 20'h9});
    // the pop lands on the edge just passed; look once it has settled
    @(negedge clk);
    `CHK(rd_valid, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(be_q, 4'h9)
    `CHK(ea, 20'h9)
    results();
  end
endmodule : tb_sync_burst_memory_port
